// ===== verilog/switch_queue_priority_control.v
// Purpose: Global queue priority, two-queue split, membership discard policy, free block count
// Assumes: Plain register port, read data one cycle after the read strobe; frame and block
//          inputs come from switch logic on clk_sys
// Notes: All outputs registered; decisions appear one cycle after frame_valid
//        Split code 01 is unused and behaves as the reset split
//        With two-queue mode off the high queue select stays low
//        Simultaneous block allocation and release leave the count unchanged
//        A mirror copy to any port outside the destinations counts as mirrored elsewhere
// Behaviour
// RULE_01: Override clear: non-event messages keep their QoS priority.
// RULE_02: Override set: non-event messages take the programmed priority, QoS ignored.
// RULE_03: Priority field bits 3:0, resets to 1111, used only while override set.
// RULE_04: Split field bits 7:6 maps two-bit priority to queue in two-queue mode.
// RULE_05: Split 00: priorities 0-2 low, 3 high; code 01 unused.
// RULE_06: Split 10, the reset value: priorities 0,1 low, 2,3 high.
// RULE_07: Split 11: priority 0 low, priorities 1-3 high.
// RULE_08: Discard bit one, reset value: frames confined to source port membership.
// RULE_09: Discard bit zero: single-destination frames bypass membership; others stay restricted.
// RULE_10: Discard zero with mirroring: single-destination frame mirrored elsewhere is dropped.
// RULE_11: Free-block field bits 26:16 shows unused packet-memory blocks in real time.
// RULE_12: With nothing buffered, including after reset, free count reads 0x3F7.
// RULE_13: Count falls on allocation, rises on release, never exceeds its maximum.
`timescale 1ns/100ps
`include "switch_queue_priority_consts.vh"

module switch_queue_priority_control #(
   parameter PORTS = 3
) (
   input wire clk_sys,
   input wire rst,
   input wire [`ADDR_W-1:0] reg_addr,
   input wire [`DATA_W-1:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [`DATA_W-1:0] reg_rdata,
   input wire frame_valid,
   input wire frame_ptp_nonevent,
   input wire [3:0] frame_qos_priority,
   input wire two_queue_mode,
   input wire [1:0] frame_regen_priority,
   input wire [PORTS-1:0] frame_dest_map,
   input wire [PORTS-1:0] frame_member_map,
   input wire mirror_enable,
   input wire [PORTS-1:0] frame_mirror_map,
   input wire block_alloc,
   input wire block_release,
   output reg decision_valid,
   output reg [3:0] queue_priority,
   output reg high_queue_select,
   output reg [PORTS-1:0] forward_map,
   output reg frame_drop,
   output reg [`FREE_COUNT_W-1:0] free_block_count
);

   reg nonevent_override;
   reg [3:0] nonevent_priority;
   reg [1:0] two_queue_priority_split;
   reg [3:0] qmc_reserved;
   reg unicast_membership_discard;
   reg qmc_reserved0;

   reg [3:0] next_queue_priority;
   reg next_high_queue;
   reg [PORTS-1:0] next_forward_map;
   reg next_drop;
   reg [`FREE_COUNT_W-1:0] next_free_count;
   reg [`DATA_W-1:0] next_rdata;

   wire single_dest;
   wire mirrored_elsewhere;
   wire bypass_allowed;
   wire nonevent_forced;
   wire [PORTS-1:0] stray_mirror;
   wire [PORTS:0] dest_count_step [0:PORTS];
   genvar g;

   // Address decode and write enables
   wire sel_nonevent;
   wire sel_queue_control;
   wire nonevent_wr;
   wire queue_control_wr;

   // Read image of each register, unused bits zero
   reg [`DATA_W-1:0] nonevent_image;
   reg [`DATA_W-1:0] queue_control_image;
   reg [`DATA_W-1:0] free_count_image;

   // High queue result under each split code
   wire split_high_0_2_low;
   wire split_high_0_1_low;
   wire split_high_0_low;

   // Counter limits and step conditions
   wire count_empty;
   wire count_full;
   wire count_down;
   wire count_up;

   assign sel_nonevent = (reg_addr == `OFS_PTP_NONEVENT_QUEUE_PRIORITY);
   assign sel_queue_control = (reg_addr == `OFS_QUEUE_MANAGEMENT_CONTROL);
   assign nonevent_wr = reg_wr && sel_nonevent;
   assign queue_control_wr = reg_wr && sel_queue_control;
   assign nonevent_forced = frame_ptp_nonevent && nonevent_override;

   // Non-event override bit
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         nonevent_override <= `NONEVENT_OVERRIDE_RST;
      end else if (nonevent_wr) begin
         nonevent_override <= reg_wdata[`NONEVENT_OVERRIDE_BIT];
      end
   end

   // Non-event priority field
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         nonevent_priority <= `NONEVENT_PRIO_RST; // [RULE_03]
      end else if (nonevent_wr) begin
         nonevent_priority <= reg_wdata[`NONEVENT_PRIO_HI:`NONEVENT_PRIO_LO]; // [RULE_03]
      end
   end

   // Two-queue split field
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         two_queue_priority_split <= `SPLIT_RST; // [RULE_06]
      end else if (queue_control_wr) begin
         two_queue_priority_split <= reg_wdata[`SPLIT_HI:`SPLIT_LO]; // [RULE_04]
      end
   end

   // Reserved bits kept as plain storage
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         qmc_reserved <= `QMC_RSV_RST;
      end else if (queue_control_wr) begin
         qmc_reserved <= reg_wdata[`QMC_RSV_HI:`QMC_RSV_LO];
      end
   end

   // Unicast membership discard bit
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         unicast_membership_discard <= `DISCARD_RST; // [RULE_08]
      end else if (queue_control_wr) begin
         unicast_membership_discard <= reg_wdata[`DISCARD_BIT];
      end
   end

   // Lowest reserved bit, plain storage
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         qmc_reserved0 <= `QMC_RSV0_RST;
      end else if (queue_control_wr) begin
         qmc_reserved0 <= reg_wdata[`QMC_RSV0_BIT];
      end
   end

   // Image of the non-event priority register
   always @* begin
      nonevent_image = {`DATA_W{1'b0}};
      nonevent_image[`NONEVENT_OVERRIDE_BIT] = nonevent_override;
      nonevent_image[`NONEVENT_PRIO_HI:`NONEVENT_PRIO_LO] = nonevent_priority;
   end

   // Image of the queue management control register
   always @* begin
      queue_control_image = {`DATA_W{1'b0}};
      queue_control_image[`SPLIT_HI:`SPLIT_LO] = two_queue_priority_split;
      queue_control_image[`QMC_RSV_HI:`QMC_RSV_LO] = qmc_reserved;
      queue_control_image[`DISCARD_BIT] = unicast_membership_discard;
      queue_control_image[`QMC_RSV0_BIT] = qmc_reserved0;
   end

   // Image of the free block register
   always @* begin
      free_count_image = {`DATA_W{1'b0}};
      free_count_image[`FREE_COUNT_HI:`FREE_COUNT_LO] = free_block_count; // [RULE_11]
   end

   // Register read mux; unmapped addresses read zero
   always @* begin
      next_rdata = {`DATA_W{1'b0}};
      case (reg_addr)
         `OFS_PTP_NONEVENT_QUEUE_PRIORITY: begin
            next_rdata = nonevent_image;
         end
         `OFS_QUEUE_MANAGEMENT_CONTROL: begin
            next_rdata = queue_control_image;
         end
         `OFS_PACKET_MEMORY_FREE_COUNT: begin
            next_rdata = free_count_image; // [RULE_11]
         end
         default: begin
            next_rdata = {`DATA_W{1'b0}};
         end
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reg_rdata <= {`DATA_W{1'b0}};
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= {`DATA_W{1'b0}};
      end
   end

   // Queue priority for the frame
   always @* begin
      if (nonevent_forced) begin
         next_queue_priority = nonevent_priority; // [RULE_02]
      end else begin
         next_queue_priority = frame_qos_priority; // [RULE_01]
      end
   end

   // Two-queue split; the unused code behaves as the reset split
   assign split_high_0_2_low = (frame_regen_priority == 2'h3); // [RULE_05]
   assign split_high_0_1_low = frame_regen_priority[1]; // [RULE_06]
   assign split_high_0_low = (frame_regen_priority != 2'h0); // [RULE_07]

   always @* begin
      case (two_queue_priority_split)
         `SPLIT_0_2_LOW: begin
            next_high_queue = split_high_0_2_low; // [RULE_05]
         end
         `SPLIT_0_LOW: begin
            next_high_queue = split_high_0_low; // [RULE_07]
         end
         default: begin
            next_high_queue = split_high_0_1_low; // [RULE_06]
         end
      endcase
      if (!two_queue_mode) begin
         next_high_queue = 1'b0; // [RULE_04]
      end
   end

   // Per-port scan: running destination count and mirror copies outside the destinations
   assign dest_count_step[0] = {(PORTS+1){1'b0}};

   generate
      for (g = 0; g < PORTS; g = g + 1) begin : port_scan
         assign dest_count_step[g+1] = dest_count_step[g] + {{PORTS{1'b0}}, frame_dest_map[g]};
         assign stray_mirror[g] = frame_mirror_map[g] && !frame_dest_map[g];
      end
   endgenerate

   assign single_dest = (dest_count_step[PORTS] == {{PORTS{1'b0}}, 1'b1});
   assign mirrored_elsewhere = mirror_enable && (|stray_mirror);
   // Only a single-destination frame may leave the membership restriction
   assign bypass_allowed = !unicast_membership_discard && single_dest; // [RULE_09]

   // Membership restriction and mirror drop
   always @* begin
      next_drop = 1'b0;
      if (!bypass_allowed) begin
         next_forward_map = frame_dest_map & frame_member_map; // [RULE_08] [RULE_09]
      end else if (mirrored_elsewhere) begin
         next_forward_map = {PORTS{1'b0}}; // [RULE_10]
         next_drop = 1'b1;
      end else begin
         next_forward_map = frame_dest_map; // [RULE_09]
      end
   end

   // Decision strobe, one cycle after each frame
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         decision_valid <= 1'b0;
      end else begin
         decision_valid <= frame_valid;
      end
   end

   // Queue priority, held until the next frame
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         queue_priority <= 4'h0;
      end else if (frame_valid) begin
         queue_priority <= next_queue_priority; // [RULE_01] [RULE_02]
      end
   end

   // High queue select, held until the next frame
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         high_queue_select <= 1'b0;
      end else if (frame_valid) begin
         high_queue_select <= next_high_queue; // [RULE_04]
      end
   end

   // Forwarding map, held until the next frame
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         forward_map <= {PORTS{1'b0}};
      end else if (frame_valid) begin
         forward_map <= next_forward_map; // [RULE_08] [RULE_09]
      end
   end

   // Drop flag, held until the next frame
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         frame_drop <= 1'b0;
      end else if (frame_valid) begin
         frame_drop <= next_drop; // [RULE_10]
      end
   end

   // Free block counter; allocation and release together cancel, both ends hold
   assign count_empty = (free_block_count == {`FREE_COUNT_W{1'b0}});
   assign count_full = (free_block_count == `FREE_COUNT_MAX);
   assign count_down = block_alloc && !block_release && !count_empty;
   assign count_up = block_release && !block_alloc && !count_full;

   always @* begin
      next_free_count = free_block_count;
      if (count_down) begin
         next_free_count = free_block_count - 11'h001; // [RULE_13]
      end else if (count_up) begin
         next_free_count = free_block_count + 11'h001; // [RULE_13]
      end
   end

   // Count register, full after reset
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         free_block_count <= `FREE_COUNT_MAX; // [RULE_12]
      end else begin
         free_block_count <= next_free_count; // [RULE_11]
      end
   end

endmodule

// ===== verilog/switch_queue_priority_consts.vh
// Purpose: Offsets, field positions, reset values and limits of the queue priority bank
// Assumes: Byte addresses as printed; 32-bit read data, narrow registers in low bits except the free count at bits 26:16
// Notes: Definitions only
`ifndef SWITCH_QUEUE_PRIORITY_CONSTS_VH
`define SWITCH_QUEUE_PRIORITY_CONSTS_VH

`define ADDR_W 16
`define DATA_W 32

`define OFS_PTP_NONEVENT_QUEUE_PRIORITY 16'h037D
`define OFS_QUEUE_MANAGEMENT_CONTROL 16'h0390
`define OFS_PACKET_MEMORY_FREE_COUNT 16'h03AC

`define NONEVENT_OVERRIDE_BIT 7
`define NONEVENT_PRIO_HI 3
`define NONEVENT_PRIO_LO 0
`define NONEVENT_OVERRIDE_RST 1'h0
`define NONEVENT_PRIO_RST 4'hF

`define SPLIT_HI 7
`define SPLIT_LO 6
`define SPLIT_RST 2'h2
`define QMC_RSV_HI 5
`define QMC_RSV_LO 2
`define QMC_RSV_RST 4'h0
`define DISCARD_BIT 1
`define DISCARD_RST 1'h1
`define QMC_RSV0_BIT 0
`define QMC_RSV0_RST 1'h0

`define SPLIT_0_2_LOW 2'h0
`define SPLIT_UNUSED 2'h1
`define SPLIT_0_1_LOW 2'h2
`define SPLIT_0_LOW 2'h3

`define FREE_COUNT_HI 26
`define FREE_COUNT_LO 16
`define FREE_COUNT_W 11
`define FREE_COUNT_MAX 11'h3F7

`endif

// ===== testbench/sqp_chk.sv
// Purpose: Assertions on the bank ports
// Assumes: One clock, rst async high
// Notes: Bound after the module
`timescale 1ns/100ps
module sqp_chk #(parameter PORTS = 3) (
   input wire clk_sys,
   input wire rst,
   input wire frame_valid,
   input wire frame_ptp_nonevent,
   input wire [3:0] frame_qos_priority,
   input wire two_queue_mode,
   input wire [1:0] frame_regen_priority,
   input wire [PORTS-1:0] frame_dest_map,
   input wire [PORTS-1:0] frame_member_map,
   input wire block_alloc,
   input wire block_release,
   input wire decision_valid,
   input wire [3:0] queue_priority,
   input wire high_queue_select,
   input wire [PORTS-1:0] forward_map,
   input wire frame_drop,
   input wire [10:0] free_block_count
);
default clocking @(posedge clk_sys);
endclocking
default disable iff (rst);
sequence alloc_s;
   block_alloc && !block_release && free_block_count != 0;
endsequence
AST_DV: assert property (##1 decision_valid == $past(frame_valid))
   else $error("decision pulse");
AST_QOS: assert property (frame_valid && !frame_ptp_nonevent
   |=> queue_priority == $past(frame_qos_priority)) else $error("qos priority");
AST_TOP: assert property (frame_valid && two_queue_mode && frame_regen_priority == 2'h3
   |=> high_queue_select) else $error("top priority low");
AST_LOW: assert property (frame_valid && frame_regen_priority == 2'h0
   |=> !high_queue_select) else $error("zero priority high");
AST_MULTI: assert property (frame_valid && $countones(frame_dest_map) != 1
   |=> !frame_drop && forward_map == $past(frame_dest_map & frame_member_map))
   else $error("multi dest");
AST_DROP: assert property (frame_drop |-> forward_map == 3'h0)
   else $error("drop forwards");
AST_DEC: assert property (alloc_s |=> free_block_count == $past(free_block_count) - 11'h1)
   else $error("alloc");
AST_MAX: assert property (free_block_count <= 11'h3F7)
   else $error("count max");
sequence release_s;
   block_release && !block_alloc && free_block_count != 11'h3F7;
endsequence
AST_INC: assert property (release_s
   |=> free_block_count == $past(free_block_count) + 11'h1) else $error("release");
endmodule
bind switch_queue_priority_control sqp_chk #(.PORTS(PORTS)) sqp_chk_inst (.*);

// ===== testbench/tb_switch_queue_priority_control.sv
// Purpose: Self-checking bench for the bank
// Assumes: Read data one cycle after strobe
// Notes: Seed 95
`timescale 1ns/100ps
module tb_switch_queue_priority_control;
reg clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, rd_d = 0;
reg [15:0] reg_addr = 0;
reg [31:0] reg_wdata = 0, r;
reg frame_valid = 0, frame_ptp_nonevent = 0, two_queue_mode = 0, mirror_enable = 0;
reg [3:0] frame_qos_priority = 0, pr = 4'hF, p;
reg [1:0] frame_regen_priority = 0, sp = 2'h2;
reg [2:0] frame_dest_map = 0, frame_member_map = 0, frame_mirror_map = 0, f;
reg block_alloc = 0, block_release = 0, ov = 0, dc = 1, h, d;
wire [31:0] reg_rdata;
wire decision_valid, high_queue_select, frame_drop;
wire [3:0] queue_priority;
wire [2:0] forward_map;
wire [10:0] free_block_count;
int miscompares = 0, cmp_count = 0, i;
logic [31:0] rq[$];
logic [8:0] fq[$];
switch_queue_priority_control #(.PORTS(3)) switch_queue_priority_control_inst (.*);
initial forever #5 clk_sys = ~clk_sys;
task chk(input string n, input [31:0] s, e);
   cmp_count++;
   if (s !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", n, e, s);
   end
endtask
task final_report;
   if (miscompares == 0 && cmp_count > 0)
      $display("RESULT: PASS");
   else
      $display("RESULT: FAIL");
   $finish;
endtask
task wr(input [15:0] a, input [31:0] v);
   @(posedge clk_sys);
   reg_wr <= 1;
   reg_addr <= a;
   reg_wdata <= v;
   if (a == 16'h037D) {ov, pr} = {v[7], v[3:0]};
   if (a == 16'h0390) {sp, dc} = {v[7:6], v[1]};
   @(posedge clk_sys);
   reg_wr <= 0;
endtask
task rd(input [15:0] a, input [31:0] e);
   @(posedge clk_sys);
   reg_rd <= 1;
   reg_addr <= a;
   rq.push_back(e);
   @(posedge clk_sys);
   reg_rd <= 0;
endtask
task blk(input a, b, input int n);
   repeat (n) begin
      @(posedge clk_sys);
      block_alloc <= a;
      block_release <= b;
   end
   @(posedge clk_sys);
   block_alloc <= 0;
   block_release <= 0;
endtask
task frame;
   r = $urandom;
   @(posedge clk_sys);
   frame_valid <= 1;
   {frame_ptp_nonevent, frame_qos_priority, frame_regen_priority} <= r[6:0];
   {frame_dest_map, frame_member_map, frame_mirror_map} <= r[15:7];
   {two_queue_mode, mirror_enable} <= r[17:16];
   p = (r[6] && ov) ? pr : r[5:2];
   h = r[17] && (sp == 0 ? r[1:0] == 3 : sp == 3 ? r[1:0] != 0 : r[1]);
   f = r[15:13] & r[12:10];
   d = 0;
   if (!dc && $countones(r[15:13]) == 1) begin
      d = r[16] && (r[9:7] & ~r[15:13]) != 0;
      f = d ? 3'h0 : r[15:13];
   end
   fq.push_back({p, h, f, d});
endtask
always @(posedge clk_sys) rd_d <= reg_rd;
always @(negedge clk_sys) begin
   if (rd_d) chk("rdata", reg_rdata, rq.pop_front());
   if (decision_valid === 1'b1) chk("decision", {queue_priority, high_queue_select,
      forward_map, frame_drop}, fq.pop_front());
end
initial begin
   #500000;
   miscompares++;
   final_report;
end
initial begin
   void'($urandom(95));
   repeat (20) @(posedge clk_sys);
   rst <= 0;
   rd(16'h037D, 32'h0F);
   rd(16'h0390, 32'h82);
   rd(16'h0100, 32'h0);
   wr(16'h03AC, 32'h0);
   rd(16'h03AC, 32'h03F70000);
   for (i = 0; i < 17; i++) begin
      repeat (12) frame;
      @(posedge clk_sys);
      frame_valid <= 0;
      r = $urandom;
      wr(16'h0390, {r[31:8], i[1:0], r[5:2], i[3], r[0]});
      wr(16'h037D, {r[31:8], i[2], r[6:0]});
      rd(16'h0390, {24'h0, i[1:0], r[5:2], i[3], r[0]});
      rd(16'h037D, {24'h0, i[2], 3'h0, r[3:0]});
   end
   blk(1, 0, 3);
   @(negedge clk_sys);
   chk("free_block_count", free_block_count, 32'h3F4);
   rd(16'h03AC, 32'h03F40000);
   blk(1, 1, 4);
   rd(16'h03AC, 32'h03F40000);
   blk(1, 0, 1100);
   rd(16'h03AC, 32'h0);
   blk(0, 1, 1100);
   @(negedge clk_sys);
   chk("free_block_count", free_block_count, 32'h3F7);
   rd(16'h03AC, 32'h03F70000);
   repeat (3) @(posedge clk_sys);
   final_report;
end
endmodule
